// >>> hw/clock_divider_distribution.sv
// Clock divider and distribution block with AXI4-Lite register access
module clock_divider_distribution (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [2:0] interrupt_level,
  input wire logic risc_busy,
  input wire logic low_power_stop_instruction,
  input wire logic pll_locked,
  input wire logic [1:0] clock_mode_straps,
  input wire logic crystal_input,
  output logic general_clock_enable,
  output logic [4:0] baud_generator_clock,
  output logic serial_sync_clock,
  output logic integration_module_clock,
  output logic clock_out_primary,
  output logic clock_out_double_rate,
  output logic [1:0] clock_out_primary_drive,
  output logic [1:0] clock_out_double_rate_drive,
  output logic pll_enable_bit,
  output logic [11:0] multiplication_factor,
  output logic prescaler_select,
  output logic pll_run
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [1:0] strap_s3;
    logic crys_s1;
    logic crys_s2;
    logic crys_s3;
    logic crys_stable;
    clock_divider_pkg::clock_divider_control_type div_ctl;
    clock_divider_pkg::pll_control_type pll_ctl;
    clock_divider_pkg::clock_output_control_type out_ctl;
    logic awready;
    logic wready;
    logic aw_ok;
    logic w_ok;
    logic [3:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    clock_divider_pkg::mode_type mode;
    logic [2:0] gen_df;
    logic [9:0] gen_cnt;
    logic [9:0] brg_cnt;
    logic [9:0] sync_cnt;
    logic [6:0] pre_cnt;
    logic xtal_half;
    logic gen_en;
    logic brg_en;
    logic sync_en;
    logic sim_en;
    logic clk1;
    logic clk2;
    logic pll_run;
  } state_type;

  state_type q;
  state_type n;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Bit 2 flags a mapped word, bits 1:0 give its index
  function automatic logic [2:0] reg_hit(input logic [3:0] addr);
    reg_hit = {1'b1, addr[3:2]};
    if (addr[1:0] != 2'h0) begin
      reg_hit = 3'h0;
    end
  endfunction : reg_hit

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] merged;
    merged = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merged[8*i +: 8] = data[8*i +: 8];
      end
    end
    apply_strb = merged & mask;
  endfunction : apply_strb

  function automatic clock_divider_pkg::pll_control_type strap_decode(input logic [1:0] s);
    strap_decode = '0;
    strap_decode.pll_enable_bit = (s != clock_divider_pkg::STRAP_PLL_OFF);
    strap_decode.prescaler_select = (s == clock_divider_pkg::STRAP_PRESCALED);
    case (s)
      clock_divider_pkg::STRAP_PLL_OFF: strap_decode.multiplication_factor = 12'h000;
      clock_divider_pkg::STRAP_EXT_CLOCK: begin
        strap_decode.multiplication_factor = clock_divider_pkg::MULT_EXT_CLOCK;
      end
      default: strap_decode.multiplication_factor = clock_divider_pkg::MULT_LOW_XTAL;
    endcase
  endfunction : strap_decode

  // Wrap at the top of a period of BASE_PERIOD << df cycles
  function automatic logic [9:0] next_count(input logic [9:0] cnt, input logic [2:0] df);
    logic [9:0] top;
    top = (clock_divider_pkg::BASE_PERIOD << df) - 10'h001;
    next_count = (cnt >= top) ? 10'h000 : cnt + 10'h001;
  endfunction : next_count

  // ----------------------------------------------------------------
  // Mode request and crystal reference
  // ----------------------------------------------------------------
  logic high_req;
  logic gen_wrap;
  logic crys_rise;
  logic xtal_tick;
  logic xtal_level;
  logic wr_pll_ctl;
  clock_divider_pkg::mode_type want_mode;
  logic [2:0] want_df;

  assign high_req = (interrupt_level > q.div_ctl.interrupt_threshold_level) ||
                    (q.div_ctl.risc_request_speedup_enable && risc_busy);
  assign gen_wrap = (next_count(q.gen_cnt, q.gen_df) == 10'h000);
  // The stable crystal level only moves once stages two and three agree
  assign crys_rise = (q.crys_s2 == q.crys_s3) && q.crys_s3 && !q.crys_stable;
  assign xtal_tick = crys_rise &&
                     (!q.pll_ctl.prescaler_select || q.pre_cnt == clock_divider_pkg::PRESCALE_TOP);
  assign xtal_level = q.pll_ctl.prescaler_select ? q.pre_cnt[6] : q.crys_stable;

  // Pick the next general clock mode and its divide factor
  always_comb begin
    want_mode = clock_divider_pkg::MODE_NORMAL;
    want_df = clock_divider_pkg::DIV_BY_ONE;
    if (low_power_stop_instruction) begin
      want_mode = clock_divider_pkg::MODE_STOP;
    end else if (!q.div_ctl.clock_source_select) begin
      want_mode = clock_divider_pkg::MODE_NORMAL;
    end else if (high_req) begin
      want_mode = clock_divider_pkg::MODE_HIGH;
      want_df = q.div_ctl.high_divide_factor;
    end else begin
      want_mode = clock_divider_pkg::MODE_LOW;
      want_df = q.div_ctl.low_divide_factor;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Single process so every flop of the block is visible in one place
  always_comb begin
    n = q;
    wr_pll_ctl = 1'b0;
    n.strap_s1 = clock_mode_straps;
    n.strap_s2 = q.strap_s1;
    n.strap_s3 = q.strap_s2;
    n.crys_s1 = crystal_input;
    n.crys_s2 = q.crys_s1;
    n.crys_s3 = q.crys_s2;
    if (q.crys_s2 == q.crys_s3) begin
      n.crys_stable = q.crys_s3;
    end
    if (crys_rise) begin
      n.pre_cnt = q.pre_cnt + 7'h01;
    end
    if (xtal_tick) begin
      n.xtal_half = !q.xtal_half;
    end
    // Register bus: address and data taken in either order
    if (awvalid && q.awready) begin
      n.aw_ok = 1'b1;
      n.waddr = awaddr;
    end
    if (wvalid && q.wready) begin
      n.w_ok = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (q.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_ok && n.w_ok && !q.bvalid) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = clock_divider_pkg::RESP_OKAY;
      case (reg_hit(n.waddr))
        3'h4: begin
          // Protect bit freezes the divider settings until reset
          if (!q.div_ctl.write_protect) begin
            n.div_ctl = apply_strb(q.div_ctl, n.wdata, n.wstrb, clock_divider_pkg::DIV_CTL_WMASK);
          end
        end
        3'h5: begin
          n.pll_ctl = apply_strb(q.pll_ctl, n.wdata, n.wstrb, clock_divider_pkg::PLL_CTL_WMASK);
          wr_pll_ctl = 1'b1;
        end
        3'h6: begin
          n.out_ctl = apply_strb(q.out_ctl, n.wdata, n.wstrb, clock_divider_pkg::OUT_CTL_WMASK);
        end
        3'h7: n.bresp = clock_divider_pkg::RESP_OKAY;
        default: n.bresp = clock_divider_pkg::RESP_SLVERR;
      endcase
    end
    if (q.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = clock_divider_pkg::RESP_OKAY;
      case (reg_hit(araddr))
        3'h4: n.rdata = q.div_ctl;
        3'h5: n.rdata = q.pll_ctl;
        3'h6: n.rdata = q.out_ctl;
        3'h7: n.rdata = {23'h000000, pll_locked, 1'b0, q.gen_df, q.mode};
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = clock_divider_pkg::RESP_SLVERR;
        end
      endcase
    end
    n.awready = !n.aw_ok && !n.bvalid;
    n.wready = !n.w_ok && !n.bvalid;
    n.arready = !n.rvalid;
    // General clock: new rate is taken only when a period ends
    n.gen_cnt = next_count(q.gen_cnt, q.gen_df);
    if (gen_wrap) begin
      n.mode = want_mode;
      n.gen_df = want_df;
    end
    n.brg_cnt = next_count(q.brg_cnt, q.div_ctl.brg_divide_factor);
    n.sync_cnt = next_count(q.sync_cnt, q.div_ctl.sync_divide_factor);
    n.brg_en = (n.brg_cnt == 10'h000);
    n.sync_en = (n.sync_cnt == 10'h000);
    // Fixed high phase, low phase grows with the divider
    // Rise only at a period start, so relock gives no short high phase
    n.clk1 = (n.gen_cnt < clock_divider_pkg::HIGH_PHASE) &&
             (n.gen_cnt == 10'h000 || q.clk1);
    n.clk2 = ((n.gen_cnt & ((clock_divider_pkg::DOUBLE_PERIOD << n.gen_df) - 10'h001))
              == 10'h000);
    n.gen_en = (n.gen_cnt == 10'h000) && (n.mode != clock_divider_pkg::MODE_STOP);
    n.sim_en = (n.gen_cnt == 10'h000);
    if (n.mode == clock_divider_pkg::MODE_STOP && !q.pll_ctl.stop_pll_keep_select) begin
      n.clk1 = n.xtal_half;
      n.clk2 = xtal_level;
      n.sim_en = xtal_tick && !q.xtal_half;
    end
    // While the loop acquires lock the core clocks halt
    if (!pll_locked) begin
      n.gen_en = 1'b0;
      n.sim_en = 1'b0;
      n.clk1 = 1'b0;
      n.clk2 = xtal_level;
    end
    n.pll_run = q.pll_ctl.pll_enable_bit &&
                !(low_power_stop_instruction && !q.pll_ctl.stop_pll_keep_select);
    // Synchronous reset still samples the straps
    if (!aresetn) begin
      n = '0;
      n.strap_s1 = clock_mode_straps;
      n.strap_s2 = q.strap_s1;
      n.strap_s3 = q.strap_s2;
      n.div_ctl = clock_divider_pkg::DIV_CTL_RESET;
      n.out_ctl = clock_divider_pkg::OUT_CTL_RESET;
      n.mode = clock_divider_pkg::MODE_NORMAL;
      n.pll_ctl = strap_decode((q.strap_s2 == q.strap_s3) ? q.strap_s3 :
                             clock_divider_pkg::STRAP_PULLUP);
    end
  end

  // Register the whole state
  always_ff @(posedge aclk) begin
    q <= n;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign general_clock_enable = q.gen_en;
  assign baud_generator_clock = {5{q.brg_en}};
  assign serial_sync_clock = q.sync_en;
  assign integration_module_clock = q.sim_en;
  assign clock_out_primary = q.clk1;
  assign clock_out_double_rate = q.clk2;
  assign clock_out_primary_drive = q.out_ctl.primary_drive;
  assign clock_out_double_rate_drive = q.out_ctl.double_rate_drive;
  assign pll_enable_bit = q.pll_ctl.pll_enable_bit;
  assign multiplication_factor = q.pll_ctl.multiplication_factor;
  assign prescaler_select = q.pll_ctl.prescaler_select;
  assign pll_run = q.pll_run;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  high_select_a: assert property (gen_wrap && q.div_ctl.clock_source_select &&
      (interrupt_level > q.div_ctl.interrupt_threshold_level) && !low_power_stop_instruction
      |=> q.mode == clock_divider_pkg::MODE_HIGH) else $error("interrupt did not speed up");
  risc_speed_a: assert property (gen_wrap && q.div_ctl.clock_source_select &&
      q.div_ctl.risc_request_speedup_enable && risc_busy && !low_power_stop_instruction
      |=> q.mode == clock_divider_pkg::MODE_HIGH) else $error("risc busy did not speed up");
  low_return_a: assert property (gen_wrap && q.div_ctl.clock_source_select && !high_req &&
      !low_power_stop_instruction |=> q.mode == clock_divider_pkg::MODE_LOW &&
      q.gen_df == $past(q.div_ctl.low_divide_factor)) else $error("no return to low rate");
  high_factor_a: assert property (gen_wrap && q.div_ctl.clock_source_select && high_req &&
      !low_power_stop_instruction |=> q.gen_df == $past(q.div_ctl.high_divide_factor))
      else $error("high factor not applied");
  undivided_a: assert property (gen_wrap && !q.div_ctl.clock_source_select &&
      !low_power_stop_instruction |=> q.gen_df == 3'h0) else $error("source zero is divided");
  duty_phase_a: assert property (disable iff (!aresetn || !pll_locked)
      $rose(q.clk1) && q.mode != clock_divider_pkg::MODE_STOP |=> q.clk1 ##1 !q.clk1)
      else $error("primary high phase not two cycles");
  brg_period_a: assert property (q.brg_en |=> !q.brg_en [*3])
      else $error("baud clock faster than base");
  sync_period_a: assert property (q.sync_en |=> !q.sync_en [*3])
      else $error("sync clock faster than base");
  sim_track_a: assert property (q.mode != clock_divider_pkg::MODE_STOP && $past(pll_locked)
      |-> q.sim_en == q.gen_en) else $error("integration clock differs from general");
  primary_rate_a: assert property ($rose(q.clk1) && $past(pll_locked) &&
      q.mode != clock_divider_pkg::MODE_STOP |-> q.sim_en && q.clk2)
      else $error("primary output out of step");
  stop_xtal_a: assert property (q.mode == clock_divider_pkg::MODE_STOP &&
      !q.pll_ctl.stop_pll_keep_select && $past(pll_locked) |-> q.clk1 == q.xtal_half)
      else $error("stop clock not crystal half");
  lock_xtal_a: assert property (!$past(pll_locked) |-> q.clk2 == $past(xtal_level) &&
      !q.clk1) else $error("double rate not crystal during lock");
  edge_switch_a: assert property ($changed(q.gen_df) |-> q.gen_cnt == 10'h000)
      else $error("rate changed mid period");
  strap_hold_a: assert property (!wr_pll_ctl |=> $stable(q.pll_ctl))
      else $error("pll control moved without a write");
  strap_load_a: assert property (disable iff (1'b0) !aresetn && q.strap_s2 == q.strap_s3 &&
      q.strap_s3 == 2'h3 |=> q.pll_ctl.multiplication_factor == 12'h190 && q.pll_ctl.pll_enable_bit)
      else $error("strap not loaded");
  reset_div_a: assert property (disable iff (1'b0) $rose(aresetn) |->
      q.div_ctl == clock_divider_pkg::DIV_CTL_RESET && q.gen_df == 3'h0) else $error("reset divide");

  high_mode_c: cover property (q.mode == clock_divider_pkg::MODE_HIGH ##1
      q.mode == clock_divider_pkg::MODE_LOW);
  stop_mode_c: cover property (q.mode == clock_divider_pkg::MODE_STOP && !q.pll_run);
  lock_loss_c: cover property (pll_locked ##1 !pll_locked);
  reg_write_c: cover property (q.bvalid && bready && q.bresp == clock_divider_pkg::RESP_OKAY);

endmodule : clock_divider_distribution

// >>> hw/clock_divider_pkg.sv
// Constants, register layouts and state encodings for the clock divider block
package clock_divider_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CLOCK_DIVIDER_CONTROL = 4'h0;
  localparam logic [3:0] OFS_PLL_CONTROL = 4'h4;
  localparam logic [3:0] OFS_CLOCK_OUTPUT_CONTROL = 4'h8;
  localparam logic [3:0] OFS_CLOCK_STATUS = 4'hc;

  // ----------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic write_protect;
    logic [11:0] rsvd_hi;
    logic [2:0] brg_divide_factor;
    logic rsvd_mid;
    logic [2:0] sync_divide_factor;
    logic risc_request_speedup_enable;
    logic [2:0] interrupt_threshold_level;
    logic clock_source_select;
    logic [2:0] high_divide_factor;
    logic rsvd_lo;
    logic [2:0] low_divide_factor;
  } clock_divider_control_type;

  typedef struct packed {
    logic [16:0] rsvd;
    logic stop_pll_keep_select;
    logic pll_enable_bit;
    logic prescaler_select;
    logic [11:0] multiplication_factor;
  } pll_control_type;

  typedef struct packed {
    logic [27:0] rsvd;
    logic [1:0] double_rate_drive;
    logic [1:0] primary_drive;
  } clock_output_control_type;

  // Writable bits; reserved bits read as zero
  localparam logic [31:0] DIV_CTL_WMASK = 32'h8007_7ff7;
  localparam logic [31:0] PLL_CTL_WMASK = 32'h0000_7fff;
  localparam logic [31:0] OUT_CTL_WMASK = 32'h0000_000f;

  // ----------------------------------------------------------------
  // Reset values and strap decode
  // ----------------------------------------------------------------
  localparam logic [31:0] DIV_CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] OUT_CTL_RESET = 32'h0000_0000;
  localparam logic [11:0] MULT_LOW_XTAL = 12'h190;
  localparam logic [11:0] MULT_EXT_CLOCK = 12'h001;
  localparam logic [1:0] STRAP_PULLUP = 2'h3;
  localparam logic [1:0] STRAP_PLL_OFF = 2'h0;
  localparam logic [1:0] STRAP_EXT_CLOCK = 2'h1;
  localparam logic [1:0] STRAP_PRESCALED = 2'h2;

  // ----------------------------------------------------------------
  // Timing counts in fast clock cycles; prescaler top in crystal rises
  // ----------------------------------------------------------------
  localparam logic [9:0] BASE_PERIOD = 10'h004;
  localparam logic [9:0] DOUBLE_PERIOD = 10'h002;
  localparam logic [9:0] HIGH_PHASE = 10'h002;
  localparam logic [6:0] PRESCALE_TOP = 7'h7f;
  localparam logic [2:0] DIV_BY_ONE = 3'h0;

  // ----------------------------------------------------------------
  // Bus responses and clock modes
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MODE_NORMAL = 4'b0001,
    MODE_HIGH = 4'b0010,
    MODE_LOW = 4'b0100,
    MODE_STOP = 4'b1000
  } mode_type;

endpackage : clock_divider_pkg

// >>> verif/clock_consumer_model.sv
// Partner model: a clock consumer that measures cycles between rising ticks
module clock_consumer_model (
  input wire logic aclk,
  input wire logic tick,
  output logic [9:0] period
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] count_q;
  logic prev_q;
  // Start clean so the first measured period is not unknown
  initial begin
    period = 10'h000;
    count_q = 10'h000;
    prev_q = 1'b0;
  end
  // Rising edge detect, so level waveforms and pulses measure alike
  always @(posedge aclk) begin
    prev_q <= tick;
    if (tick && !prev_q) begin
      period <= count_q + 10'h001;
      count_q <= 10'h000;
    end else begin
      count_q <= count_q + 10'h001;
    end
  end
endmodule : clock_consumer_model

// >>> verif/tb_top.sv
// Self-checking testbench for the clock divider and distribution block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, risc_busy, low_power_stop_instruction;
  logic pll_locked, crystal_input, general_clock_enable, serial_sync_clock;
  logic integration_module_clock, clock_out_primary, clock_out_double_rate;
  logic pll_enable_bit, prescaler_select, pll_run;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, clock_mode_straps;
  logic [1:0] clock_out_primary_drive, clock_out_double_rate_drive;
  logic [2:0] interrupt_level;
  logic [4:0] baud_generator_clock;
  logic [11:0] multiplication_factor;
  logic [9:0] gen_p, baud_p, sync_p, sim_p, pri_p, dbl_p;
  logic [33:0] exp_q[$];
  int mismatches = 0;
  int samples_checked = 0;

  clock_divider_distribution DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .interrupt_level, .risc_busy,
    .low_power_stop_instruction, .pll_locked, .clock_mode_straps, .crystal_input,
    .general_clock_enable, .baud_generator_clock, .serial_sync_clock,
    .integration_module_clock, .clock_out_primary, .clock_out_double_rate,
    .clock_out_primary_drive, .clock_out_double_rate_drive, .pll_enable_bit,
    .multiplication_factor, .prescaler_select, .pll_run);
  // Consumers on the far side, one per distributed clock
  clock_consumer_model m_gen (.aclk(aclk), .tick(general_clock_enable), .period(gen_p));
  clock_consumer_model m_brg (.aclk(aclk), .tick(baud_generator_clock[4]), .period(baud_p));
  clock_consumer_model m_syn (.aclk(aclk), .tick(serial_sync_clock), .period(sync_p));
  clock_consumer_model m_sim (.aclk(aclk), .tick(integration_module_clock), .period(sim_p));
  clock_consumer_model m_pri (.aclk(aclk), .tick(clock_out_primary), .period(pri_p));
  clock_consumer_model m_dbl (.aclk(aclk), .tick(clock_out_double_rate), .period(dbl_p));

  // ------------------------------------------------------------
  // Clocks, compare and bus tasks
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Crystal is much slower than aclk, toggling on aclk falling edges
  initial begin
    crystal_input = 1'b0;
    forever #400 crystal_input = ~crystal_input;
  end

  task automatic check(input string name, input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  // Wait three general clock ticks so the period models hold the new rate
  task automatic settle;
    int n;
    n = 0;
    for (int i = 0; i < 300 && n < 3; i++) begin
      @(posedge aclk);
      #1;
      if (general_clock_enable === 1'b1) n++;
    end
    if (n < 3) begin
      mismatches++;
      summarize();
    end
  endtask : settle

  // Samples at the falling edge see what the next rising edge will take
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_s, w_s, b_s;
    logic [1:0] r_s;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_s = 1'b0;
    for (int i = 0; i < 100 && !b_s; i++) begin
      @(negedge aclk);
      aw_s = awvalid & awready;
      w_s = wvalid & wready;
      b_s = bvalid;
      r_s = bresp;
      @(posedge aclk);
      if (aw_s) awvalid <= 1'b0;
      if (w_s) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!b_s) begin
      mismatches++;
      summarize();
    end
    check("bresp", {32'h0, r_s}, {32'h0, er});
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, input logic [33:0] e);
    logic ar_s, r_s;
    @(posedge aclk);
    exp_q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_s = 1'b0;
    for (int i = 0; i < 100 && !r_s; i++) begin
      @(negedge aclk);
      ar_s = arvalid & arready;
      r_s = rvalid;
      @(posedge aclk);
      if (ar_s) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!r_s) begin
      mismatches++;
      summarize();
    end
  endtask : axi_read

  // Read data watcher takes the oldest expected note per handshake
  always @(negedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0) begin
      check("read", {rresp, rdata}, exp_q.pop_front());
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(66));
    {aresetn, awvalid, wvalid, bready, arvalid, rready, risc_busy} = 7'h00;
    {awaddr, araddr, wstrb, wdata, interrupt_level} = 47'h0;
    low_power_stop_instruction = 1'b0;
    pll_locked = 1'b1;
    clock_mode_straps = 2'h3;
    repeat (16) @(posedge aclk);
    check("mult", {22'h0, multiplication_factor}, {22'h0, clock_divider_pkg::MULT_LOW_XTAL});
    aresetn <= 1'b1;
    clock_mode_straps <= 2'h1;
    settle;
    check("mult", {22'h0, multiplication_factor}, {22'h0, clock_divider_pkg::MULT_LOW_XTAL});
    check("gen", {24'h0, gen_p}, 34'h4);
    check("dbl", {24'h0, dbl_p}, 34'h2);
    axi_read(clock_divider_pkg::OFS_CLOCK_DIVIDER_CONTROL, 34'h0);
    axi_read(clock_divider_pkg::OFS_PLL_CONTROL, 34'h2190);
    // Baud and sync factors stay zero: sync never below general
    axi_write(clock_divider_pkg::OFS_CLOCK_DIVIDER_CONTROL, 32'hb92, 2'h0);
    axi_read(clock_divider_pkg::OFS_CLOCK_DIVIDER_CONTROL, 34'hb92);
    interrupt_level <= 3'h3;
    settle;
    check("gen", {24'h0, gen_p}, 34'h10);
    check("pri", {24'h0, pri_p}, 34'h10);
    check("sim", {24'h0, sim_p}, 34'h10);
    check("dbl", {24'h0, dbl_p}, 34'h8);
    check("brg", {24'h0, baud_p}, 34'h4);
    check("sync", {24'h0, sync_p}, 34'h4);
    interrupt_level <= 3'h4 + 3'($urandom % 4);
    settle;
    check("gen", {24'h0, gen_p}, 34'h8);
    interrupt_level <= 3'h0;
    risc_busy <= 1'b1;
    settle;
    check("gen", {24'h0, gen_p}, 34'h8);
    axi_write(clock_divider_pkg::OFS_CLOCK_DIVIDER_CONTROL, 32'h392, 2'h0);
    settle;
    check("gen", {24'h0, gen_p}, 34'h10);
    axi_write(clock_divider_pkg::OFS_CLOCK_DIVIDER_CONTROL, 32'h312, 2'h0);
    settle;
    check("gen", {24'h0, gen_p}, 34'h4);
    for (int i = 0; i < 4; i++) begin
      axi_write(clock_divider_pkg::OFS_CLOCK_OUTPUT_CONTROL, 32'(i * 4 + 3 - i), 2'h0);
      check("drv", {30'h0, clock_out_double_rate_drive, clock_out_primary_drive},
        34'(i * 4 + 3 - i));
    end
    // Stop with the loop off: primary and integration clocks run at crystal halves
    @(posedge aclk);
    low_power_stop_instruction <= 1'b1;
    repeat (200) @(posedge aclk);
    #1;
    check("run", {33'h0, pll_run}, 34'h0);
    check("pri", {24'h0, pri_p}, 34'h40);
    check("sim", {24'h0, sim_p}, 34'h40);
    @(posedge aclk);
    low_power_stop_instruction <= 1'b0;
    pll_locked <= 1'b0;
    repeat (100) @(posedge aclk);
    #1;
    check("pri", {33'h0, clock_out_primary}, 34'h0);
    check("dbl", {24'h0, dbl_p}, 34'h20);
    @(posedge aclk);
    pll_locked <= 1'b1;
    settle;
    check("gen", {24'h0, gen_p}, 34'h4);
    axi_write(4'h2, 32'h1, clock_divider_pkg::RESP_SLVERR);
    axi_read(4'h1, {clock_divider_pkg::RESP_SLVERR, 32'h0});
    repeat (4) @(posedge aclk);
    summarize();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    summarize();
  end
endmodule : tb_top
